//--- hdl/cps_sequencer.sv
// Configuration word, start-up timers, halt wake-up and AXI4-Lite access.
`timescale 1ns/10ps
`default_nettype none
module cps_sequencer #(
  parameter int POWER_UP_DELAY_TIMER_CYCLES = cps_pkg::POWER_UP_DELAY_TIMER_CYCLES
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        oscillator_input_pin,
  input  wire logic        wdt_osc_tick,
  input  wire logic        ext_reset_req,
  input  wire logic        irq_wake,
  output logic             oscillator_output_pin,
  output logic             core_reset_n,
  output logic             wdt_timeout
);

  // Address within the test space decoded from a 14-bit program address.
  function automatic logic in_test_space(input logic [13:0] addr);
    in_test_space = (addr >= cps_pkg::TEST_SPACE_LO) && (addr <= cps_pkg::TEST_SPACE_HI);
  endfunction : in_test_space

  // Register and bus state.
  logic [13:0]          config_word;
  logic [13:0]          next_config_word;
  logic                 prog_mode;
  logic                 next_prog_mode;
  logic                 halt_req;
  logic                 next_halt_req;
  logic                 aw_held;
  logic                 next_aw_held;
  logic [7:0]           aw_addr;
  logic [7:0]           next_aw_addr;
  logic                 w_held;
  logic                 next_w_held;
  logic [31:0]          w_data;
  logic [31:0]          next_w_data;
  logic                 next_awready;
  logic                 next_wready;
  logic                 next_bvalid;
  logic [1:0]           next_bresp;
  logic                 next_arready;
  logic                 next_rvalid;
  logic [31:0]          next_rdata;
  logic [1:0]           next_rresp;

  // Sequencer state.
  cps_pkg::cps_state_e  state;
  cps_pkg::cps_state_e  next_state;
  logic [31:0]          power_up_delay_timer_cnt;
  logic [31:0]          next_power_up_delay_timer_cnt;
  logic [10:0]          ost_cnt;
  logic [10:0]          next_ost_cnt;
  logic                 osc_prev;
  logic                 next_osc_prev;
  logic [1:0]           div_cnt;
  logic [1:0]           next_div_cnt;
  logic                 next_osc_out;
  logic [12:0]          wdt_cnt;
  logic [12:0]          next_wdt_cnt;
  logic                 wdt_wake;
  logic                 next_wdt_wake;
  logic                 next_wdt_timeout;
  logic                 next_core_reset_n;

  // Decoded configuration fields.
  cps_pkg::cps_osc_mode_e osc_mode;
  logic                   wdt_enabled;
  logic                   power_up_delay_timer_enabled;
  logic                   crystal_mode;
  logic                   osc_rise;
  logic                   wr_fire;
  cps_pkg::cps_status_s   status;

  // Unprogrammed bits read 1; a programmed 0 enables the power-up delay timer but disables the watchdog.
  assign osc_mode     = cps_pkg::cps_osc_mode_e'({config_word[cps_pkg::OSC_MODE_SEL_HI_POS],
                          config_word[cps_pkg::OSC_MODE_SEL_LO_POS]});
  assign wdt_enabled  = config_word[cps_pkg::WDT_EN_POS];
  assign power_up_delay_timer_enabled = ~config_word[cps_pkg::POWER_UP_DELAY_TIMER_EN_N_POS];
  assign crystal_mode = (osc_mode != cps_pkg::RESISTOR_CAPACITOR_MODE);
  assign osc_rise     = oscillator_input_pin & ~osc_prev;
  assign wr_fire      = aw_held & w_held & ~s_axi_bvalid;
  assign status       = '{wdt_wake: wdt_wake, core_reset_n: core_reset_n, state: state};

  // Register bus: address and data may arrive in either order.
  always_comb begin
    next_aw_held     = aw_held;
    next_aw_addr     = aw_addr;
    next_w_held      = w_held;
    next_w_data      = w_data;
    next_config_word = config_word;
    next_prog_mode   = prog_mode;
    next_halt_req    = 1'b0;
    next_bvalid      = s_axi_bvalid & ~s_axi_bready;
    next_bresp       = s_axi_bresp;
    next_arready     = ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
    next_rvalid      = s_axi_rvalid & ~s_axi_rready;
    next_rdata       = s_axi_rdata;
    next_rresp       = s_axi_rresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
    end
    next_awready = ~next_aw_held & ~s_axi_awready;
    next_wready  = ~next_w_held & ~s_axi_wready;
    if (wr_fire) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = cps_pkg::RESP_OKAY;
      unique case (aw_addr)
        cps_pkg::REG_CONFIG: begin
          // Writing the configuration word is a programming-mode access only.
          if (prog_mode && in_test_space(cps_pkg::CONFIG_WORD_ADDR)) begin
            next_config_word = w_data[13:0];
          end else begin
            next_bresp = cps_pkg::RESP_SLVERR;
          end
        end
        cps_pkg::REG_CONTROL: begin
          next_prog_mode = w_data[cps_pkg::CTL_PROG_MODE_POS];
          next_halt_req  = w_data[cps_pkg::CTL_HALT_POS];
        end
        default: next_bresp = cps_pkg::RESP_SLVERR;
      endcase
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp  = cps_pkg::RESP_OKAY;
      next_rdata  = 32'h0000_0000;
      unique case (s_axi_araddr)
        cps_pkg::REG_CONFIG: begin
          if (prog_mode) begin
            next_rdata = {18'h0_0000, config_word};
          end else begin
            next_rresp = cps_pkg::RESP_SLVERR;
          end
        end
        cps_pkg::REG_CONTROL: next_rdata = {30'h0000_0000, 1'b0, prog_mode};
        cps_pkg::REG_STATUS:  next_rdata = {28'h000_0000, status};
        default:              next_rresp = cps_pkg::RESP_SLVERR;
      endcase
    end
  end

  // Start-up sequence, halt, watchdog and clock output.
  always_comb begin
    next_state       = state;
    next_power_up_delay_timer_cnt    = power_up_delay_timer_cnt;
    next_ost_cnt     = ost_cnt;
    next_osc_prev    = oscillator_input_pin;
    next_div_cnt     = div_cnt;
    next_osc_out     = 1'b0;
    next_wdt_cnt     = wdt_cnt;
    next_wdt_wake    = wdt_wake;
    next_wdt_timeout = 1'b0;
    // The watchdog counts only its own tick, and only the configuration bit stops it.
    if (wdt_enabled && wdt_osc_tick) begin
      next_wdt_cnt = wdt_cnt + 13'h0001;
      if (wdt_cnt == 13'(cps_pkg::WDT_PERIOD_TICK - 1)) begin
        next_wdt_cnt     = 13'h0000;
        next_wdt_timeout = 1'b1;
      end
    end
    if (!wdt_enabled) begin
      next_wdt_cnt = 13'h0000;
    end
    // RC mode drives the oscillator divided by four on the output pin.
    if (osc_mode == cps_pkg::RESISTOR_CAPACITOR_MODE) begin
      if (osc_rise) begin
        next_div_cnt = div_cnt + 2'h1;
      end
      next_osc_out = div_cnt[1];
    end
    unique case (state)
      cps_pkg::ST_POWER_UP_DELAY_TIMER: begin
        if (!power_up_delay_timer_enabled || power_up_delay_timer_cnt >= 32'(POWER_UP_DELAY_TIMER_CYCLES - 1)) begin
          next_state   = crystal_mode ? cps_pkg::ST_OST : cps_pkg::ST_RUN;
          next_ost_cnt = 11'h000;
        end else begin
          next_power_up_delay_timer_cnt = power_up_delay_timer_cnt + 32'h0000_0001;
        end
      end
      cps_pkg::ST_OST: begin
        if (osc_rise) begin
          next_ost_cnt = ost_cnt + 11'h001;
        end
        if (ost_cnt == 11'(cps_pkg::OST_OSC_CYCLES)) begin
          next_state = cps_pkg::ST_RUN;
        end
      end
      cps_pkg::ST_RUN: begin
        if (halt_req) begin
          next_state    = cps_pkg::ST_HALT;
          next_wdt_wake = 1'b0;
        end
      end
      cps_pkg::ST_HALT: begin
        if (ext_reset_req || irq_wake || next_wdt_timeout) begin
          next_wdt_wake = next_wdt_timeout;
          next_state    = crystal_mode ? cps_pkg::ST_OST : cps_pkg::ST_RUN;
          next_ost_cnt  = 11'h000;
        end
      end
    endcase
    next_core_reset_n = (next_state == cps_pkg::ST_RUN) || (next_state == cps_pkg::ST_HALT);
  end

  // Registers for both groups.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      config_word           <= cps_pkg::CONFIG_RESET;
      prog_mode             <= 1'b0;
      halt_req              <= 1'b0;
      aw_held               <= 1'b0;
      aw_addr               <= 8'h00;
      w_held                <= 1'b0;
      w_data                <= 32'h0000_0000;
      s_axi_awready         <= 1'b0;
      s_axi_wready          <= 1'b0;
      s_axi_bvalid          <= 1'b0;
      s_axi_bresp           <= cps_pkg::RESP_OKAY;
      s_axi_arready         <= 1'b0;
      s_axi_rvalid          <= 1'b0;
      s_axi_rdata           <= 32'h0000_0000;
      s_axi_rresp           <= cps_pkg::RESP_OKAY;
      state                 <= cps_pkg::ST_POWER_UP_DELAY_TIMER;
      power_up_delay_timer_cnt              <= 32'h0000_0000;
      ost_cnt               <= 11'h000;
      osc_prev              <= 1'b0;
      div_cnt               <= 2'h0;
      oscillator_output_pin <= 1'b0;
      wdt_cnt               <= 13'h0000;
      wdt_wake              <= 1'b0;
      wdt_timeout           <= 1'b0;
      core_reset_n          <= 1'b0;
    end else begin
      config_word           <= next_config_word;
      prog_mode             <= next_prog_mode;
      halt_req              <= next_halt_req;
      aw_held               <= next_aw_held;
      aw_addr               <= next_aw_addr;
      w_held                <= next_w_held;
      w_data                <= next_w_data;
      s_axi_awready         <= next_awready;
      s_axi_wready          <= next_wready;
      s_axi_bvalid          <= next_bvalid;
      s_axi_bresp           <= next_bresp;
      s_axi_arready         <= next_arready;
      s_axi_rvalid          <= next_rvalid;
      s_axi_rdata           <= next_rdata;
      s_axi_rresp           <= next_rresp;
      state                 <= next_state;
      power_up_delay_timer_cnt              <= next_power_up_delay_timer_cnt;
      ost_cnt               <= next_ost_cnt;
      osc_prev              <= next_osc_prev;
      div_cnt               <= next_div_cnt;
      oscillator_output_pin <= next_osc_out;
      wdt_cnt               <= next_wdt_cnt;
      wdt_wake              <= next_wdt_wake;
      wdt_timeout           <= next_wdt_timeout;
      core_reset_n          <= next_core_reset_n;
    end
  end

endmodule : cps_sequencer
`default_nettype wire

//--- hdl/cps_pkg.sv
// Package with constants and types for the configuration and power-up sequencer.
package cps_pkg;

  // Configuration word address and the test/configuration space bounds.
  localparam logic [13:0] CONFIG_WORD_ADDR = 14'h2007;
  localparam logic [13:0] TEST_SPACE_LO    = 14'h2000;
  localparam logic [13:0] TEST_SPACE_HI    = 14'h3fff;

  // Configuration word field positions.
  localparam int OSC_MODE_SEL_LO_POS = 0;
  localparam int OSC_MODE_SEL_HI_POS = 1;
  localparam int WDT_EN_POS          = 2;
  localparam int POWER_UP_DELAY_TIMER_EN_N_POS       = 3;

  // Unprogrammed configuration word reads as all ones.
  localparam logic [13:0] CONFIG_RESET = 14'h3fff;

  // AXI4-Lite register byte offsets.
  localparam logic [7:0] REG_CONFIG  = 8'h00;
  localparam logic [7:0] REG_CONTROL = 8'h04;
  localparam logic [7:0] REG_STATUS  = 8'h08;

  // Control register bit positions.
  localparam int CTL_PROG_MODE_POS = 0;
  localparam int CTL_HALT_POS      = 1;

  // Timing: 72 ms power-up delay at 50 MHz and 1024 oscillator cycles.
  localparam longint POWER_UP_DELAY_TIMER_DELAY_MS   = 72;
  localparam longint CLK_HZ          = 50000000;
  localparam int     POWER_UP_DELAY_TIMER_CYCLES     = int'((POWER_UP_DELAY_TIMER_DELAY_MS * CLK_HZ) / 1000);
  localparam int     OST_OSC_CYCLES  = 1024;
  localparam int     WDT_PERIOD_TICK = 4096;

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Oscillator modes selected by the two mode bits.
  typedef enum logic [1:0] {
    LOW_POWER_CRYSTAL_MODE  = 2'b00,
    CRYSTAL_RESONATOR_MODE  = 2'b01,
    HIGH_SPEED_CRYSTAL_MODE = 2'b10,
    RESISTOR_CAPACITOR_MODE = 2'b11
  } cps_osc_mode_e;

  // Sequencer states.
  typedef enum logic [1:0] {
    ST_POWER_UP_DELAY_TIMER = 2'b00,
    ST_OST  = 2'b01,
    ST_RUN  = 2'b10,
    ST_HALT = 2'b11
  } cps_state_e;

  // Status returned to software.
  typedef struct packed {
    logic       wdt_wake;
    logic       core_reset_n;
    cps_state_e state;
  } cps_status_s;

endpackage : cps_pkg

//--- tb/cps_seq_chk.sv
// Checker for the sequencer's bus answers, watchdog pulse, clock output and reset.
`timescale 1ns/10ps
`default_nettype none
module cps_seq_chk #(
  parameter int POWER_UP_DELAY_TIMER_CYCLES = 20
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        oscillator_input_pin,
  input wire logic        oscillator_output_pin,
  input wire logic        wdt_osc_tick,
  input wire logic        wdt_timeout,
  input wire logic        core_reset_n
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Input and bus writes quiet long enough for the divider to settle.
  sequence in_still;
    ($stable(oscillator_input_pin) && !s_axi_wvalid) [*6];
  endsequence
  // Write address and data taken together.
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  reset_quiet_a: assert property (disable iff (1'h0) !aresetn |=>
    !core_reset_n && !wdt_timeout && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs not cleared by reset");
  write_resp_a: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  read_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  wdt_single_a: assert property (wdt_timeout |=> !wdt_timeout)
    else $error("watchdog pulse too long");
  wdt_cause_a: assert property (wdt_timeout |->
    $past(wdt_osc_tick) || $past(wdt_osc_tick, 2)) else $error("watchdog fired without tick");
  clkout_still_a: assert property (in_still |=> $stable(oscillator_output_pin))
    else $error("clock output moved without input edge");
endmodule : cps_seq_chk

bind cps_sequencer cps_seq_chk #(.POWER_UP_DELAY_TIMER_CYCLES(POWER_UP_DELAY_TIMER_CYCLES)) u_chk (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .oscillator_input_pin, .oscillator_output_pin,
  .wdt_osc_tick, .wdt_timeout, .core_reset_n);
`default_nettype wire

//--- tb/cps_osc_model.sv
// Model of an external clock source driving the oscillator input pin.
`timescale 1ns/10ps
`default_nettype none
module cps_osc_model #(
  parameter real HALF_NS = 31.0
) (
  input  wire logic run,
  output var  logic clk_out
);
  // Free-running clock while enabled, held low while stopped.
  initial clk_out = 1'h0;
  always begin
    #(HALF_NS);
    clk_out = run ? ~clk_out : 1'h0;
  end
endmodule : cps_osc_model
`default_nettype wire

//--- tb/tb.sv
// Self-checking bench for the configuration and power-up sequencer.
`timescale 1ns/10ps
`default_nettype none
module tb;
  localparam logic [1:0] OK = cps_pkg::RESP_OKAY;
  localparam logic [1:0] ER = cps_pkg::RESP_SLVERR;
  localparam logic [7:0] CFG = cps_pkg::REG_CONFIG;
  localparam logic [7:0] CTL = cps_pkg::REG_CONTROL;
  localparam logic [7:0] STA = cps_pkg::REG_STATUS;
  logic        aclk = 1'h0, aresetn = 1'h0, osc_run = 1'h0, in_q = 1'h0, out_q = 1'h0;
  logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, oscillator_input_pin;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        wdt_osc_tick = 1'h0, ext_reset_req = 1'h0, irq_wake = 1'h0;
  logic        oscillator_output_pin, core_reset_n, wdt_timeout;
  int          error_cnt = 0, checks = 0, in_rises = 0, out_rises = 0;
  always #10 aclk = ~aclk;
  cps_osc_model u_osc (.run(osc_run), .clk_out(oscillator_input_pin));
  cps_sequencer #(.POWER_UP_DELAY_TIMER_CYCLES(20)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .oscillator_input_pin,
    .wdt_osc_tick, .ext_reset_req, .irq_wake, .oscillator_output_pin, .core_reset_n,
    .wdt_timeout);
  // Counts rising edges on the oscillator pins as seen from the bus clock.
  always @(posedge aclk) begin
    in_q <= oscillator_input_pin;
    out_q <= oscillator_output_pin;
    if (oscillator_input_pin && !in_q) in_rises <= in_rises + 1;
    if (oscillator_output_pin && !out_q) out_rises <= out_rises + 1;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  // Full write: address and data offered together, each released once taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
    chk(s_axi_bresp, er);
  endtask : wr
  // Full read with response compared, and data too when OKAY is expected.
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 1'h0;
    chk(s_axi_rresp, er);
    if (er == OK) chk(s_axi_rdata, ed);
  endtask : rd
  task automatic t_bus;
    rd(STA, 32'h6, OK);
    rd(CFG, 32'h0, ER);
    wr(CFG, 32'h0, ER);
    rd(8'h0c, 32'h0, ER);
    wr(CTL, 32'h1, OK);
    rd(CFG, {18'h0, cps_pkg::CONFIG_RESET}, OK);
    for (int m = 3; m >= 0; m--) begin
      wr(CFG, 32'h3ffc + m, OK);
      rd(CFG, 32'h3ffc + m, OK);
    end
    $display("bus test done");
  endtask : t_bus
  task automatic t_rc;
    int n0;
    wr(CFG, 32'h3fff, OK);
    n0 = out_rises;
    osc_run <= 1'h1;
    repeat (40 * 62 / 20) @(posedge aclk);
    osc_run <= 1'h0;
    chk((out_rises - n0) inside {[9:11]}, 1'h1);
    $display("clock output test done");
  endtask : t_rc
  task automatic t_xt;
    int n0, n1;
    wr(CFG, 32'h3ffd, OK);
    wr(CTL, 32'h3, OK);
    rd(STA, 32'h7, OK);
    irq_wake <= 1'h1;
    repeat (3) @(posedge aclk);
    irq_wake <= 1'h0;
    repeat (20) @(posedge aclk);
    chk(core_reset_n, 1'h0);
    n0 = in_rises;
    n1 = out_rises;
    osc_run <= 1'h1;
    while (core_reset_n !== 1'h1) @(posedge aclk);
    osc_run <= 1'h0;
    chk((in_rises - n0) inside {[1024:1027]}, 1'h1);
    chk(out_rises - n1, 32'h0);
    rd(STA, 32'h6, OK);
    $display("start-up timer test done");
  endtask : t_xt
  task automatic t_ext;
    wr(CFG, 32'h3fff, OK);
    wr(CTL, 32'h3, OK);
    rd(STA, 32'h7, OK);
    ext_reset_req <= 1'h1;
    repeat (2) @(posedge aclk);
    ext_reset_req <= 1'h0;
    rd(STA, 32'h6, OK);
    $display("external wake test done");
  endtask : t_ext
  task automatic t_wdt;
    int n;
    logic seen;
    n = 0;
    seen = 1'h0;
    wr(CTL, 32'h3, OK);
    while (wdt_timeout !== 1'h1) begin
      wdt_osc_tick <= ~wdt_osc_tick;
      @(posedge aclk);
      if (wdt_osc_tick) n++;
    end
    wdt_osc_tick <= 1'h0;
    chk(n inside {[4096:4097]}, 1'h1);
    rd(STA, 32'he, OK);
    wr(CFG, 32'h3ffb, OK);
    repeat (8400) begin
      wdt_osc_tick <= ~wdt_osc_tick;
      @(posedge aclk);
      if (wdt_timeout) seen = 1'h1;
    end
    chk(seen, 1'h0);
    $display("watchdog test done");
  endtask : t_wdt
  task automatic end_sim;
    $display("checks %0d, mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_sim
  // Main sequence after ten cycles of reset.
  initial begin : main
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (10) @(posedge aclk);
    t_bus();
    t_rc();
    t_xt();
    t_ext();
    t_wdt();
    end_sim();
  end
  // Cuts a hang short well after the tests should have ended.
  initial begin : guard
    repeat (60000) @(posedge aclk);
    error_cnt++;
    end_sim();
  end
endmodule : tb
`default_nettype wire
